/* File: hw/plhld_pkg.sv */
// Purpose: Shared constants for the holdover and lock control block
// Assumes: One 25 MHz core clock, register port with byte addresses
// Notes: Offsets follow the device register map

package plhld_pkg;

  // ----------------------------------------
  // Register addresses
  // ----------------------------------------
  localparam logic [9:0] ADDR_STATUS_CTRL = 10'h017;
  localparam logic [9:0] ADDR_LOCK_DET = 10'h018;
  localparam logic [9:0] ADDR_LOCK_PIN_CTRL = 10'h01A;
  localparam logic [9:0] ADDR_REFERENCE_MONITOR_PIN_CTRL = 10'h01B;
  localparam logic [9:0] ADDR_REF_SEL = 10'h01C;
  localparam logic [9:0] ADDR_HOLDOVER = 10'h01D;
  localparam logic [9:0] ADDR_FREQ_MON = 10'h01F;
  localparam logic [9:0] ADDR_GATED_EN_A = 10'h0FC;
  localparam logic [9:0] ADDR_GATED_EN_B = 10'h0FD;
  localparam logic [9:0] ADDR_CHDIV0_CTRL = 10'h191;
  localparam logic [9:0] ADDR_CHDIV1_CTRL = 10'h194;
  localparam logic [9:0] ADDR_CHDIV2_CTRL = 10'h197;
  localparam logic [9:0] ADDR_CHDIV3_CTRL = 10'h19A;

  // ----------------------------------------
  // Field positions and codes
  // ----------------------------------------
  localparam int LDC_CNT_LSB = 5;
  localparam int LDC_WIN_BIT = 4;
  localparam int LDC_DIS_BIT = 3;
  localparam int HO_CMP_EN_BIT = 3;
  localparam int HO_EXT_BIT = 1;
  localparam int HO_EN_BIT = 0;
  localparam int REF_AUTO_BIT = 4;
  localparam int REF_PREF_BIT = 3;
  localparam int REF_BUF_LSB = 1;
  localparam int CHDIV_IGN_SYNC_BIT = 6;
  localparam int STATUS_SEL_LSB = 2;
  localparam logic [5:0] LOCK_PIN_CURRENT_SRC = 6'h04;
  localparam logic [5:0] STATUS_SEL_CMP = 6'h3F;
  localparam logic [4:0] REFERENCE_MONITOR_PIN_SEL_CMP = 5'h1F;
  localparam logic [7:0] REG_RESET = 8'h00;

  // ----------------------------------------
  // Lock counter lengths per field code
  // ----------------------------------------
  localparam logic [7:0] LOCK_CNT_CODE0 = 8'h05;
  localparam logic [7:0] LOCK_CNT_CODE1 = 8'h10;
  localparam logic [7:0] LOCK_CNT_CODE2 = 8'h40;
  localparam logic [7:0] LOCK_CNT_CODE3 = 8'hFF;

  // Holdover states
  typedef enum logic [2:0]
  {
    HO_RUN = 3'b001,
    HO_HOLD = 3'b010,
    HO_REARM = 3'b100
  } plhld_state_e;

endpackage : plhld_pkg

/* File: hw/plhld_ctrl.sv */
// Purpose: Lock qualification and charge-pump holdover control
// Assumes: PFD events and comparator result arrive as core_clk pulses/levels
// Notes: Analog lock detect and monitor thresholds live outside this block

module plhld_ctrl
  import plhld_pkg::*;
#(
  parameter int NUM_OUTPUTS = 16
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic reg_wr,
  input wire logic [9:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic pfd_ref_edge,
  input wire logic pfd_in_lock_window,
  input wire logic pfd_in_unlock_window,
  input wire logic lock_pin_cmp,
  input wire logic sync_n,
  input wire logic ref_present,
  input wire logic [2:0] freq_below,
  output logic lock_pin_source,
  output logic lock_pin_clamp,
  output logic digital_lock_flag,
  output logic charged_lock_qualifier,
  output logic reference_monitor_pin,
  output logic status_pin,
  output logic [NUM_OUTPUTS-1:0] out_enable,
  output logic [3:0] chan_sync_off,
  output logic cp_tristate,
  output logic b_counter_reset,
  output logic lock_window_high,
  output logic ref_auto_switch,
  output logic ref_prefer_second,
  output logic [1:0] ref_buf_en,
  output logic [7:0] freq_mon_cfg,
  output logic [2:0] freq_flags
);

  initial
  begin
    if (NUM_OUTPUTS < 1 || NUM_OUTPUTS > 16)
      $error("NUM_OUTPUTS must be 1 to 16");
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] status_ctrl, lock_det, lock_pin_ctrl, reference_monitor_pin_ctrl;
  logic [7:0] ref_sel, holdover_ctrl, freq_mon, gated_en_a, gated_en_b;
  logic [3:0] ign_sync;

  // Register writes
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      status_ctrl <= REG_RESET;
      lock_det <= REG_RESET;
      lock_pin_ctrl <= REG_RESET;
      reference_monitor_pin_ctrl <= REG_RESET;
      ref_sel <= REG_RESET;
      holdover_ctrl <= REG_RESET;
      freq_mon <= REG_RESET;
      gated_en_a <= REG_RESET;
      gated_en_b <= REG_RESET;
      ign_sync <= 4'h0;
    end
    else if (clk_en && reg_wr)
    begin
      unique case (reg_addr)
        ADDR_STATUS_CTRL: status_ctrl <= reg_wdata;
        ADDR_LOCK_DET: lock_det <= reg_wdata;
        ADDR_LOCK_PIN_CTRL: lock_pin_ctrl <= reg_wdata;
        ADDR_REFERENCE_MONITOR_PIN_CTRL: reference_monitor_pin_ctrl <= reg_wdata;
        ADDR_REF_SEL: ref_sel <= reg_wdata;
        ADDR_HOLDOVER: holdover_ctrl <= reg_wdata;
        ADDR_FREQ_MON: freq_mon <= reg_wdata;
        ADDR_GATED_EN_A: gated_en_a <= reg_wdata;
        ADDR_GATED_EN_B: gated_en_b <= reg_wdata;
        ADDR_CHDIV0_CTRL: ign_sync[0] <= reg_wdata[CHDIV_IGN_SYNC_BIT];
        ADDR_CHDIV1_CTRL: ign_sync[1] <= reg_wdata[CHDIV_IGN_SYNC_BIT];
        ADDR_CHDIV2_CTRL: ign_sync[2] <= reg_wdata[CHDIV_IGN_SYNC_BIT];
        ADDR_CHDIV3_CTRL: ign_sync[3] <= reg_wdata[CHDIV_IGN_SYNC_BIT];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Decoded controls
  // ----------------------------------------
  wire logic ld_enable = ~lock_det[LDC_DIS_BIT];
  wire logic [1:0] ld_cnt_code = lock_det[LDC_CNT_LSB +: 2];
  wire logic cmp_enable = holdover_ctrl[HO_CMP_EN_BIT];
  wire logic ho_enable = holdover_ctrl[HO_EN_BIT];
  wire logic ho_external = holdover_ctrl[HO_EXT_BIT];
  wire logic current_mode = (lock_pin_ctrl[5:0] == LOCK_PIN_CURRENT_SRC);
  wire logic lock_sensed = cmp_enable ? lock_pin_cmp : 1'b1;

  // Required in-window count for a field code
  function automatic logic [7:0] lock_count_len(input logic [1:0] code);
    unique case (code)
      2'b00: lock_count_len = LOCK_CNT_CODE0;
      2'b01: lock_count_len = LOCK_CNT_CODE1;
      2'b10: lock_count_len = LOCK_CNT_CODE2;
      default: lock_count_len = LOCK_CNT_CODE3;
    endcase
  endfunction : lock_count_len

  // ----------------------------------------
  // Digital lock detect
  // ----------------------------------------
  logic [7:0] lock_cnt;
  wire logic [7:0] lock_target = lock_count_len(ld_cnt_code);

  // Count in-window PFD cycles; one cycle outside the unlock window drops lock
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      lock_cnt <= 8'h00;
      digital_lock_flag <= 1'b0;
    end
    else if (clk_en)
    begin
      if (!ld_enable)
      begin
        lock_cnt <= 8'h00;
        digital_lock_flag <= 1'b0;
      end
      else if (pfd_ref_edge)
      begin
        if (digital_lock_flag)
        begin
          if (!pfd_in_unlock_window)
          begin
            digital_lock_flag <= 1'b0;
            lock_cnt <= 8'h00;
          end
        end
        else if (!pfd_in_lock_window)
          lock_cnt <= 8'h00;
        else if (lock_cnt + 8'h01 >= lock_target)
          digital_lock_flag <= 1'b1;
        else
          lock_cnt <= lock_cnt + 8'h01;
      end
    end
  end

  // ----------------------------------------
  // Lock pin drive and pin routing
  // ----------------------------------------
  assign lock_pin_source = current_mode & digital_lock_flag;
  assign lock_pin_clamp = current_mode & ~digital_lock_flag;
  assign charged_lock_qualifier = current_mode & lock_sensed;
  assign reference_monitor_pin = (reference_monitor_pin_ctrl[4:0] == REFERENCE_MONITOR_PIN_SEL_CMP)
    & lock_pin_cmp;
  assign status_pin = (status_ctrl[STATUS_SEL_LSB +: 6] == STATUS_SEL_CMP)
    & lock_pin_cmp;

  // Gated output enables, combinational so they follow the qualifier at once
  wire logic [15:0] gated_all = {gated_en_b, gated_en_a};
  assign out_enable = gated_all[NUM_OUTPUTS-1:0]
    & {NUM_OUTPUTS{charged_lock_qualifier}};

  // Channel outputs stop on low sync unless told to ignore it
  assign chan_sync_off = ~ign_sync & {4{~sync_n}};

  assign lock_window_high = ~lock_det[LDC_WIN_BIT];
  assign ref_auto_switch = ref_sel[REF_AUTO_BIT];
  assign ref_prefer_second = ref_sel[REF_PREF_BIT];
  assign ref_buf_en = ref_sel[REF_BUF_LSB +: 2];
  assign freq_mon_cfg = freq_mon;
  assign freq_flags = freq_below;

  // ----------------------------------------
  // Holdover state machine
  // ----------------------------------------
  plhld_state_e state, next_state;
  logic sync_q;
  wire logic sync_fall = sync_q & ~sync_n;
  wire logic man_enter = ho_enable & ho_external & sync_fall;
  wire logic auto_enter = ho_enable & ~ho_external & ~lock_sensed;
  // Release needs sync high in manual mode and a present reference edge
  wire logic release_ok = pfd_ref_edge & ref_present
    & (~ho_external | sync_n);

  // Next-state decode
  always_comb
  begin
    next_state = state;
    unique case (state)
      HO_RUN:
        if (man_enter || auto_enter)
          next_state = HO_HOLD;
      HO_HOLD:
        if (!ho_enable)
          next_state = HO_RUN;
        else if (release_ok)
          next_state = ho_external ? HO_RUN : HO_REARM;
      HO_REARM:
        if (man_enter)
          next_state = HO_HOLD;
        else if (digital_lock_flag && lock_sensed)
          next_state = HO_RUN;
      default: next_state = HO_RUN;
    endcase
  end

  // State, sync edge history and B counter reset pulse
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state <= HO_RUN;
      sync_q <= 1'b1;
      b_counter_reset <= 1'b0;
    end
    else if (clk_en)
    begin
      state <= next_state;
      sync_q <= sync_n;
      b_counter_reset <= (state == HO_HOLD) && ho_enable && release_ok;
    end
  end

  // Tristate asserted combinationally on the entry event itself
  // Master enable masks the held state at once, before the state register catches up
  assign cp_tristate = (state == HO_HOLD & ho_enable) | man_enter
    | (state == HO_RUN & auto_enter);

  // Readback
  always_comb
  begin
    unique case (reg_addr)
      ADDR_STATUS_CTRL: reg_rdata = status_ctrl;
      ADDR_LOCK_DET: reg_rdata = lock_det;
      ADDR_LOCK_PIN_CTRL: reg_rdata = lock_pin_ctrl;
      ADDR_REFERENCE_MONITOR_PIN_CTRL: reg_rdata = reference_monitor_pin_ctrl;
      ADDR_REF_SEL: reg_rdata = ref_sel;
      ADDR_HOLDOVER: reg_rdata = {holdover_ctrl[7:5], cp_tristate, holdover_ctrl[3:0]};
      ADDR_FREQ_MON: reg_rdata = freq_mon;
      ADDR_GATED_EN_A: reg_rdata = gated_en_a;
      ADDR_GATED_EN_B: reg_rdata = gated_en_b;
      ADDR_CHDIV0_CTRL: reg_rdata = {1'b0, ign_sync[0], 6'h00};
      ADDR_CHDIV1_CTRL: reg_rdata = {1'b0, ign_sync[1], 6'h00};
      ADDR_CHDIV2_CTRL: reg_rdata = {1'b0, ign_sync[2], 6'h00};
      ADDR_CHDIV3_CTRL: reg_rdata = {1'b0, ign_sync[3], 6'h00};
      default: reg_rdata = 8'h00;
    endcase
  end

endmodule : plhld_ctrl

/* File: sim/plhld_assertions.sv */
// Purpose: Port checks for the holdover and lock control block
// Assumes: Holdover control is tracked from register writes
// Notes: Lock run length is checked for counter code 00 only
module plhld_assertions
  import plhld_pkg::*;
#(
  parameter int NUM_OUTPUTS = 16
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic reg_wr,
  input wire logic [9:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic pfd_ref_edge,
  input wire logic pfd_in_lock_window,
  input wire logic pfd_in_unlock_window,
  input wire logic sync_n,
  input wire logic ref_present,
  input wire logic lock_pin_source,
  input wire logic lock_pin_clamp,
  input wire logic digital_lock_flag,
  input wire logic charged_lock_qualifier,
  input wire logic [NUM_OUTPUTS-1:0] out_enable,
  input wire logic cp_tristate,
  input wire logic b_counter_reset
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  logic [7:0] ho;
  logic [2:0] cnt;
  // ----------------------------------------
  // Holdover copy and in-window run length
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      ho <= REG_RESET;
      cnt <= 3'h0;
    end
    else if (clk_en)
    begin
      if (reg_wr && reg_addr == ADDR_HOLDOVER)
        ho <= reg_wdata;
      if (pfd_ref_edge)
        cnt <= !pfd_in_lock_window ? 3'h0 : (cnt == 3'h7 ? cnt : cnt + 3'h1);
    end
  end
  a_pin_lock: assert property ((lock_pin_source || lock_pin_clamp) |-> lock_pin_source == digital_lock_flag)
    else $error("lock pin drive disagrees with lock flag");
  a_gate_qual: assert property (out_enable != '0 |-> charged_lock_qualifier)
    else $error("output enabled without qualifier");
  a_master_off: assert property (!ho[HO_EN_BIT] |-> !cp_tristate)
    else $error("tristate while holdover disabled");
  a_sync_edge: assert property (ho[1:0] == 2'h3 && $fell(sync_n) |-> cp_tristate)
    else $error("sync fall did not tristate");
  a_release_evt: assert property ($fell(cp_tristate) && ho[HO_EN_BIT] |-> $past(pfd_ref_edge && ref_present) && b_counter_reset)
    else $error("release without reference event");
  a_breset_cause: assert property (b_counter_reset |-> $past(pfd_ref_edge) && !cp_tristate)
    else $error("stray counter reset");
  a_hold_noref: assert property (cp_tristate && !ref_present && ho[HO_EN_BIT] |=> cp_tristate || !ho[HO_EN_BIT])
    else $error("left hold with no reference");
  a_lock_count: assert property ($rose(digital_lock_flag) |-> cnt >= 3'h5)
    else $error("lock before five in-window cycles");
  a_lock_keep: assert property (digital_lock_flag && pfd_ref_edge && pfd_in_unlock_window |=> digital_lock_flag)
    else $error("lock dropped inside unlock window");
endmodule : plhld_assertions

/* File: sim/plhld_far_side.sv */
// Purpose: Reference, phase windows and lock pin capacitor
// Assumes: One reference event every PFD_DIV core clocks
// Notes: Window levels scramble between events
module plhld_far_side
#(
  parameter int PFD_DIV = 4,
  parameter int CAP_TRIP = 12
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ref_on,
  input wire logic phase_ok,
  input wire logic phase_near,
  input wire logic lock_pin_source,
  input wire logic lock_pin_clamp,
  output logic pfd_ref_edge,
  output logic pfd_in_lock_window,
  output logic pfd_in_unlock_window,
  output logic ref_present,
  output logic lock_pin_cmp
);
  timeunit 1ns;
  timeprecision 1ns;
  int div;
  int charge;
  logic tgl;
  // Event divider and capacitor charge
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      div <= 0;
      charge <= 0;
      tgl <= 1'b0;
    end
    else
    begin
      tgl <= !tgl;
      div <= (div == PFD_DIV - 1) ? 0 : div + 1;
      if (lock_pin_clamp)
        charge <= 0;
      else if (lock_pin_source && charge < CAP_TRIP)
        charge <= charge + 1;
    end
  end
  // Outputs; windows meaningless between events
  assign ref_present = ref_on;
  assign pfd_ref_edge = ref_on && div == 0;
  assign pfd_in_lock_window = pfd_ref_edge ? phase_ok : tgl;
  assign pfd_in_unlock_window = pfd_ref_edge ? (phase_ok || phase_near) : !tgl;
  assign lock_pin_cmp = charge >= CAP_TRIP;
endmodule : plhld_far_side

/* File: sim/testbench.sv */
// Purpose: Self-checking bench for the holdover and lock control block
// Assumes: Far side model makes reference events and lock pin charge
// Notes: Writes leave one idle cycle between strobes
module testbench
  import plhld_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk, rst, clk_en, reg_wr, sync_n, ref_on, phase_ok, phase_near, ref_present;
  logic pfd_ref_edge, pfd_in_lock_window, pfd_in_unlock_window, lock_pin_cmp;
  logic lock_pin_source, lock_pin_clamp, digital_lock_flag, charged_lock_qualifier;
  logic reference_monitor_pin, status_pin, cp_tristate, b_counter_reset;
  logic lock_window_high, ref_auto_switch, ref_prefer_second;
  logic [9:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, freq_mon_cfg;
  logic [15:0] out_enable;
  logic [3:0] chan_sync_off;
  logic [1:0] ref_buf_en;
  logic [2:0] freq_flags;
  int failures, cmp_count;
  plhld_ctrl u_dut (.freq_below(3'h5), .*);
  plhld_far_side u_far (.*);
  // ----------------------------------------
  // Clock and shared tasks
  // ----------------------------------------
  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  task automatic tick(input int n = 1);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : final_report
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    tick();
    reg_wr = 1'b0;
    tick();
  endtask : wr
  task automatic rd(input logic [9:0] a, input logic [7:0] exp, input string what);
    reg_addr = a;
    tick();
    chk(reg_rdata, exp, what);
  endtask : rd
  task automatic wait_v(ref logic s, input logic v, input string what);
    repeat (2000)
      if (s !== v)
        tick();
    chk(s, v, what);
    if (s !== v)
      final_report();
  endtask : wait_v
  // Register reset values, readback and pass-through fields
  task automatic t_regs();
    rd(ADDR_GATED_EN_A, 8'h00, "gate a reset");
    chk(lock_window_high, 1'h1, "window range");
    wr(ADDR_GATED_EN_A, 8'hA5);
    wr(ADDR_GATED_EN_B, 8'h3C);
    wr(10'h3FF, 8'hFF);
    rd(10'h3FF, 8'h00, "unmapped");
    rd(ADDR_GATED_EN_B, 8'h3C, "gate b");
    clk_en = 1'b0;
    wr(ADDR_GATED_EN_A, 8'h11);
    clk_en = 1'b1;
    rd(ADDR_GATED_EN_A, 8'hA5, "frozen write");
    wr(ADDR_REF_SEL, 8'h16);
    chk({ref_auto_switch, ref_prefer_second, ref_buf_en}, 4'hB, "ref sel");
    wr(ADDR_FREQ_MON, 8'h01);
    chk({freq_mon_cfg, 5'h00, freq_flags}, 16'h0105, "freq mon");
  endtask : t_regs
  // Lock qualification, pin drive and gated outputs
  task automatic t_lock();
    wr(ADDR_LOCK_PIN_CTRL, 8'h04);
    wr(ADDR_STATUS_CTRL, 8'hFC);
    wr(ADDR_REFERENCE_MONITOR_PIN_CTRL, 8'h1F);
    wr(ADDR_HOLDOVER, 8'h08);
    ref_on = 1'b1;
    phase_ok = 1'b1;
    wait_v(digital_lock_flag, 1'b1, "lock flag");
    chk({lock_pin_source, out_enable[0]}, 2'h2, "source early");
    wait_v(lock_pin_cmp, 1'b1, "cap charged");
    chk(out_enable, 16'h3CA5, "gated on");
    chk({status_pin, reference_monitor_pin}, 2'h3, "cmp route");
    phase_ok = 1'b0;
    phase_near = 1'b1;
    tick(12);
    chk(digital_lock_flag, 1'b1, "near keeps");
    phase_near = 1'b0;
    wait_v(lock_pin_clamp, 1'b1, "clamp");
    tick();
    chk(out_enable, 16'h0000, "gated off");
    wr(ADDR_HOLDOVER, 8'h00);
    chk(out_enable, 16'h3CA5, "cmp off");
  endtask : t_lock
  // Manual holdover by sync falling edge
  task automatic t_manual();
    wr(ADDR_HOLDOVER, 8'h02);
    sync_n = 1'b0;
    tick();
    chk({cp_tristate, chan_sync_off}, 5'h0F, "master off");
    wr(ADDR_HOLDOVER, 8'h0B);
    chk(cp_tristate, 1'b0, "level only");
    sync_n = 1'b1;
    wr(ADDR_CHDIV0_CTRL, 8'h40);
    ref_on = 1'b0;
    sync_n = 1'b0;
    tick();
    chk({cp_tristate, chan_sync_off}, 5'h1E, "sync fall");
    sync_n = 1'b1;
    tick(20);
    chk(cp_tristate, 1'b1, "no ref hold");
    ref_on = 1'b1;
    wait_v(cp_tristate, 1'b0, "release");
    chk(b_counter_reset, 1'b1, "b reset");
  endtask : t_manual
  // Automatic holdover, release and re-arm
  task automatic t_auto();
    phase_ok = 1'b1;
    wr(ADDR_HOLDOVER, 8'h08);
    wait_v(lock_pin_cmp, 1'b1, "relock");
    wr(ADDR_HOLDOVER, 8'h09);
    sync_n = 1'b0;
    tick();
    chk(cp_tristate, 1'b0, "sync ignored");
    sync_n = 1'b1;
    phase_ok = 1'b0;
    wait_v(cp_tristate, 1'b1, "auto entry");
    ref_on = 1'b0;
    tick(20);
    chk(cp_tristate, 1'b1, "auto hold");
    ref_on = 1'b1;
    wait_v(cp_tristate, 1'b0, "auto release");
    tick(12);
    chk(cp_tristate, 1'b0, "no reentry");
    phase_ok = 1'b1;
    wait_v(lock_pin_cmp, 1'b1, "lock again");
    phase_ok = 1'b0;
    wait_v(cp_tristate, 1'b1, "reentry");
  endtask : t_auto
  // Main sequence
  initial
  begin
    rst = 1'b1;
    reg_wr = 1'b0;
    clk_en = 1'b1;
    reg_addr = 10'h000;
    reg_wdata = 8'h00;
    sync_n = 1'b1;
    ref_on = 1'b0;
    phase_ok = 1'b0;
    phase_near = 1'b0;
    failures = 0;
    cmp_count = 0;
    tick(20);
    rst = 1'b0;
    tick();
    t_regs();
    $display("regs done");
    t_lock();
    $display("lock done");
    t_manual();
    $display("manual done");
    t_auto();
    $display("auto done");
    final_report();
  end
endmodule : testbench
bind plhld_ctrl plhld_assertions #(.NUM_OUTPUTS(NUM_OUTPUTS)) u_chk (.*);
